/* File: src/scsm_consts.vh */
/*
 * constants for the safety channel status monitor: widths, thresholds,
 * counter limits and flag positions.
 * assumes supply voltage arrives as an unsigned code in millivolts.
 */
`ifndef SCSM_CONSTS_VH
`define SCSM_CONSTS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define SCSM_CNT_W        8
`define SCSM_NODE_W       6
`define SCSM_MV_W         16
`define SCSM_MAX_NODES    32

// ----------------------------------------
// supply thresholds in millivolts
// ----------------------------------------
`define SCSM_LOW_TRIP_MV  16'h4f4c
`define SCSM_LOW_REC_MV   16'h4fb0
`define SCSM_HIGH_TRIP_MV 16'h6978
`define SCSM_HIGH_REC_MV  16'h6720

// ----------------------------------------
// diagnostic condition vector positions
// ----------------------------------------
`define SCSM_DIAG_N       5
`define SCSM_DG_CHERR     0
`define SCSM_DG_LOW       1
`define SCSM_DG_HIGH      2
`define SCSM_DG_INT       3
`define SCSM_DG_SYNC      4

`endif

/* File: src/scsm_event_counter.v */
/*
 * diagnostic event counter: one step per edge of each condition bit,
 * wrapping past the top value to one, never to zero.
 * assumes the condition vector is synchronous to mclk; scsm_top feeds it unregistered.
 */
`timescale 1ns/1ps
`include "scsm_consts.vh"

module scsm_event_counter #(
	parameter N = `SCSM_DIAG_N,
	parameter W = `SCSM_CNT_W
) (
	// clock and reset
	input  wire         mclk,
	input  wire         rst_b,
	// conditions
	input  wire [N-1:0] cond,
	// count
	output reg  [W-1:0] count
);

reg  [N-1:0] cond_d;
wire [N-1:0] edges;
reg  [W-1:0] next_count;
integer      i;

assign edges = cond ^ cond_d;

// ----------------------------------------
// count edges, skip zero on wrap
// ----------------------------------------
always @*
begin
	next_count = count;
	for (i = 0; i < N; i = i + 1)
	begin
		if (edges[i])
		begin
			next_count = next_count + {{(W-1){1'b0}}, 1'b1}; // [RULE12]
			if (next_count == {W{1'b0}})
			begin
				next_count = {{(W-1){1'b0}}, 1'b1}; // [RULE13]
			end
		end
	end
end

always @(posedge mclk)
begin
	if (!rst_b)
	begin
		cond_d <= {N{1'b0}};
		count <= {W{1'b0}}; // [RULE13]
	end
	else
	begin
		cond_d <= cond;
		count <= next_count;
	end
end

endmodule

/* File: src/scsm_top.v */
/*
 * safety channel status monitor: derives channel and module status flags
 * from link, node and supply observations, and counts diagnostic edges.
 * assumes all inputs are synchronous to mclk; rst_b stands for power cycle.
 */
// Behaviour
// RULE1: upstream link break raises demand, error, unkeyed; drops operational; keeps tally.
// RULE2: link restored with new terminated node clears flags, sets operational, tally plus one.
// RULE3: unverified node sets error, error sets demand, operational drops to safe.
// RULE4: configuration-only node addition leaves operational at one.
// RULE5: with link up and terminator present, device counts and types nodes itself.
// RULE6: node appended without link break stays inactive; other party breaks link first.
// RULE7: run flag zero when not running or faulted; then channel reports safe.
// RULE8: controller drives link lost flag: zero connected, one not.
// RULE9: diagnostics pending is one while any diagnostic condition is present.
// RULE10: time sync ok is one while synchronized with grandmaster.
// RULE11: time sync lost set when once synchronized but no longer.
// RULE12: event counter advances on each condition onset and each clearance.
// RULE13: counter clears on power cycle and skips zero on wrap.
// RULE14: low supply warn sets below lower threshold, clears at recovery threshold.
// RULE15: high supply warn sets above trip point, clears on return to normal.
// RULE16: internal error flag reflects internal fault presence.
// RULE17: ring mode flag is one in ring mode.
// RULE18: demand flag one when any node has a safety demand.
// RULE19: error flag ORs channel conditions, forced when disabled, feeds pending and counter.
// RULE20: operational one only when every node's safety conditions valid.
// RULE21: all status flags update together in one registered image; diag_event_counter is registered again and lags them by one clock.
`timescale 1ns/1ps
`include "scsm_consts.vh"

module scsm_top #(
	parameter NODE_W = `SCSM_NODE_W,
	parameter CNT_W  = `SCSM_CNT_W,
	parameter MV_W   = `SCSM_MV_W,
	parameter MAX_NODES = `SCSM_MAX_NODES
) (
	// clock and reset
	input  wire              mclk,
	input  wire              rst_b,
	// chain observations
	input  wire              link_up,
	input  wire              term_present,
	input  wire              term_bad,
	input  wire              node_pulse,
	input  wire              node_keyed,
	input  wire              node_demand,
	input  wire              chan_enable,
	// module observations
	input  wire              run_mode_in,
	input  wire              recov_fault,
	input  wire              nonrecov_fault,
	input  wire              internal_fault,
	input  wire              conn_lost_in,
	input  wire              sync_locked,
	input  wire              ring_mode_in,
	input  wire [MV_W-1:0]   supply_mv,
	// channel status
	output reg               chan_demand_flag,
	output reg               chan_error_flag,
	output reg               chan_operational_flag,
	output reg               chan_unkeyed_node,
	output reg  [NODE_W-1:0] node_tally,
	output reg               too_many_nodes,
	// module status
	output reg               run_state_flag,
	output reg               link_lost_flag,
	output reg               diag_pending_flag,
	output reg               time_sync_ok,
	output reg               time_sync_lost,
	output reg               supply_low_warn,
	output reg               supply_high_warn,
	output reg               internal_error_flag,
	output reg               ring_mode_flag,
	output reg  [CNT_W-1:0]  diag_event_counter
);

// ----------------------------------------
// discovery state
// ----------------------------------------
localparam ST_DOWN = 2'b00;
localparam ST_SCAN = 2'b01;
localparam ST_UP   = 2'b10;
localparam [NODE_W:0] MAX_CNT = MAX_NODES[NODE_W:0];

reg  [1:0]        state;
reg  [1:0]        next_state;
reg  [NODE_W:0]   scan_cnt;
reg  [NODE_W:0]   next_scan_cnt;
reg  [NODE_W-1:0] next_tally;
reg               all_keyed;
reg               next_all_keyed;
reg               any_demand;
reg               next_any_demand;
reg               sync_seen;
wire [CNT_W-1:0]  count;

// ----------------------------------------
// chain discovery after link restore
// ----------------------------------------
always @*
begin
	next_state = state;
	next_scan_cnt = scan_cnt;
	next_tally = node_tally;
	next_all_keyed = all_keyed;
	next_any_demand = any_demand;
	case (state)
		ST_DOWN:
		begin
			// tally held while the link is broken [RULE1]
			if (link_up && term_present) // [RULE5] [RULE6]
			begin
				next_state = ST_SCAN;
				next_scan_cnt = {(NODE_W+1){1'b0}};
				next_all_keyed = 1'b1;
				next_any_demand = 1'b0;
			end
		end
		ST_SCAN:
		begin
			if (!link_up)
			begin
				next_state = ST_DOWN;
			end
			else if (node_pulse)
			begin
				if (scan_cnt != {(NODE_W+1){1'b1}})
				begin
					// saturate so a runaway chain still reads as overflow
					next_scan_cnt = scan_cnt + {{NODE_W{1'b0}}, 1'b1}; // [RULE5]
				end
				if (!node_keyed)
				begin
					next_all_keyed = 1'b0;
				end
				if (node_demand)
				begin
					next_any_demand = 1'b1;
				end
			end
			else if (term_present)
			begin
				// scan closes at the terminator [RULE2]
				next_state = ST_UP;
				next_tally = scan_cnt[NODE_W-1:0];
			end
		end
		ST_UP:
		begin
			if (!link_up) // [RULE1]
			begin
				next_state = ST_DOWN;
				next_all_keyed = 1'b0;
			end
			else if (node_pulse)
			begin
				// live demand updates from a running chain
				next_any_demand = node_demand;
				if (!node_keyed)
				begin
					// running node failing keying drops chain to safe [RULE3]
					next_all_keyed = 1'b0;
				end
			end
		end
		default:
		begin
			next_state = ST_DOWN;
		end
	endcase
end

always @(posedge mclk)
begin
	if (!rst_b)
	begin
		state <= ST_DOWN;
		scan_cnt <= {(NODE_W+1){1'b0}};
		all_keyed <= 1'b0;
		any_demand <= 1'b0;
	end
	else
	begin
		state <= next_state;
		scan_cnt <= next_scan_cnt;
		all_keyed <= next_all_keyed;
		any_demand <= next_any_demand;
	end
end

// ----------------------------------------
// warning hysteresis: set wins, clear on recovery
// ----------------------------------------
function hyst_next;
	input cur;
	input set_cond;
	input clr_cond;
	begin
		if (set_cond)
		begin
			hyst_next = 1'b1;
		end
		else if (clr_cond)
		begin
			hyst_next = 1'b0;
		end
		else
		begin
			hyst_next = cur;
		end
	end
endfunction

// ----------------------------------------
// combined status image
// ----------------------------------------
wire chain_ok;
wire run_ok;
wire unkeyed;
wire overflow;
wire ch_err;
wire ch_dem;
wire ch_op;
wire next_low;
wire next_high;
wire next_sync_lost;
wire [`SCSM_DIAG_N-1:0] diag;

assign run_ok = run_mode_in && !recov_fault && !nonrecov_fault && !internal_fault; // [RULE7]
assign chain_ok = (state == ST_UP);
assign unkeyed = !chain_ok || !all_keyed; // [RULE1] [RULE3]
assign overflow = (scan_cnt > MAX_CNT);
assign ch_err = unkeyed || term_bad || overflow || !chan_enable; // [RULE19] [RULE3]
assign ch_dem = any_demand || ch_err; // [RULE18] [RULE3]
// configuration-only additions never reach these inputs [RULE4]
assign ch_op = chain_ok && !ch_dem && run_ok; // [RULE20] [RULE7]

assign next_low = hyst_next(supply_low_warn, supply_mv < `SCSM_LOW_TRIP_MV,
                            supply_mv >= `SCSM_LOW_REC_MV); // [RULE14]
assign next_high = hyst_next(supply_high_warn, supply_mv > `SCSM_HIGH_TRIP_MV,
                             supply_mv <= `SCSM_HIGH_REC_MV); // [RULE15]
assign next_sync_lost = sync_seen && !sync_locked; // [RULE11]

assign diag[`SCSM_DG_CHERR] = ch_err;
assign diag[`SCSM_DG_LOW]   = next_low;
assign diag[`SCSM_DG_HIGH]  = next_high;
assign diag[`SCSM_DG_INT]   = internal_fault;
assign diag[`SCSM_DG_SYNC]  = next_sync_lost;

always @(posedge mclk)
begin
	if (!rst_b)
	begin
		chan_demand_flag <= 1'b1;
		chan_error_flag <= 1'b1;
		chan_operational_flag <= 1'b0;
		chan_unkeyed_node <= 1'b1;
		node_tally <= {NODE_W{1'b0}};
		too_many_nodes <= 1'b0;
	end
	else
	begin
		// one registered image for every flag [RULE21]
		chan_demand_flag <= ch_dem; // [RULE18]
		chan_error_flag <= ch_err; // [RULE19]
		chan_operational_flag <= ch_op; // [RULE20]
		chan_unkeyed_node <= unkeyed; // [RULE3]
		node_tally <= next_tally; // [RULE2]
		too_many_nodes <= overflow;
	end
end

// ----------------------------------------
// module status image
// ----------------------------------------
always @(posedge mclk)
begin
	if (!rst_b)
	begin
		run_state_flag <= 1'b0;
		link_lost_flag <= 1'b1;
		diag_pending_flag <= 1'b0;
		time_sync_ok <= 1'b0;
		time_sync_lost <= 1'b0;
		sync_seen <= 1'b0;
		supply_low_warn <= 1'b0;
		supply_high_warn <= 1'b0;
		internal_error_flag <= 1'b0;
		ring_mode_flag <= 1'b0;
	end
	else
	begin
		// same edge as the channel image [RULE21]
		run_state_flag <= run_ok; // [RULE7]
		link_lost_flag <= conn_lost_in; // [RULE8]
		diag_pending_flag <= |diag; // [RULE9]
		time_sync_ok <= sync_locked; // [RULE10]
		sync_seen <= sync_seen || sync_locked;
		time_sync_lost <= next_sync_lost; // [RULE11]
		supply_low_warn <= next_low; // [RULE14]
		supply_high_warn <= next_high; // [RULE15]
		internal_error_flag <= internal_fault; // [RULE16]
		ring_mode_flag <= ring_mode_in; // [RULE17]
	end
end

// ----------------------------------------
// event counter
// ----------------------------------------
scsm_event_counter #(
	.N (`SCSM_DIAG_N),
	.W (CNT_W)
) u_evt (
	.mclk  (mclk),
	.rst_b (rst_b),
	.cond  (diag),
	.count (count)
);

always @(posedge mclk)
begin
	if (!rst_b)
	begin
		diag_event_counter <= {CNT_W{1'b0}};
	end
	else
	begin
		diag_event_counter <= count; // [RULE12]
	end
end

endmodule

/* File: tb/scsm_top_asserts.sv */
/* port checker for scsm_top.
   assumes bind onto scsm_top, constants header on the include path. */
`timescale 1ns/1ps
`include "scsm_consts.vh"
module scsm_top_chk #(
	parameter MV_W  = 16,
	parameter CNT_W = 8
) (
	// clock, reset and observations
	input wire             mclk, rst_b, link_up, internal_fault, ring_mode_in,
	input wire             run_mode_in, recov_fault, nonrecov_fault,
	input wire [MV_W-1:0]  supply_mv,
	// status
	input wire             chan_demand_flag, chan_error_flag, chan_operational_flag,
	input wire             chan_unkeyed_node, run_state_flag, internal_error_flag,
	input wire             time_sync_ok, time_sync_lost, supply_low_warn, supply_high_warn,
	input wire             ring_mode_flag,
	input wire [CNT_W-1:0] diag_event_counter
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	run_off_a: assert property ((!run_mode_in || recov_fault || nonrecov_fault) |=> !run_state_flag)
		else $error("run flag set while stopped or faulted");
	run_safe_a: assert property (!run_state_flag |-> !chan_operational_flag)
		else $error("channel operational while not running");
	link_break_a: assert property (!link_up |-> ##2 (chan_unkeyed_node && chan_error_flag && !chan_operational_flag))
		else $error("link break flags wrong");
	op_clean_a: assert property (chan_operational_flag |-> !(chan_error_flag || chan_demand_flag || chan_unkeyed_node))
		else $error("operational with error or demand");
	int_err_a: assert property (rst_b |=> internal_error_flag == $past(internal_fault))
		else $error("internal error flag wrong");
	ring_mode_a: assert property (rst_b |=> ring_mode_flag == $past(ring_mode_in))
		else $error("ring mode flag wrong");
	sync_excl_a: assert property (time_sync_lost |-> !time_sync_ok)
		else $error("sync lost and ok together");
	low_set_a: assert property (supply_mv < `SCSM_LOW_TRIP_MV |=> supply_low_warn)
		else $error("low supply not flagged");
	high_set_a: assert property (supply_mv > `SCSM_HIGH_TRIP_MV |=> supply_high_warn)
		else $error("high supply not flagged");
	no_zero_a: assert property (diag_event_counter != 0 |=> diag_event_counter != 0)
		else $error("event counter returned to zero");
endmodule
bind scsm_top scsm_top_chk #(.MV_W(MV_W), .CNT_W(CNT_W)) chk_i (.mclk, .rst_b, .link_up, .internal_fault,
	.ring_mode_in, .run_mode_in, .recov_fault, .nonrecov_fault, .supply_mv, .chan_demand_flag,
	.chan_error_flag, .chan_operational_flag, .chan_unkeyed_node, .run_state_flag, .internal_error_flag,
	.time_sync_ok, .time_sync_lost, .supply_low_warn, .supply_high_warn, .ring_mode_flag, .diag_event_counter);

/* File: tb/scsm_ctrl_model.sv */
/* controller side: reports whether a connection exists.
   assumes the bench says when it is connected. */
`timescale 1ns/1ps
module scsm_ctrl_model (
	input  wire mclk,
	input  wire connected,
	output reg  conn_lost_in
);
	initial conn_lost_in = 1'b1;
	always @(posedge mclk)
		conn_lost_in <= ~connected;
endmodule

/* File: tb/safety_channel_status_monitor_tb.sv */
/* self-checking bench for scsm_top.
   assumes the controller model drives the connection indication. */
`timescale 1ns/1ps
module safety_channel_status_monitor_tb;
	logic mclk, rst_b, link_up, term_present, node_pulse, node_keyed, node_demand, chan_enable;
	logic run_mode_in, recov_fault, nonrecov_fault, internal_fault, sync_locked, ring_mode_in, connected, term_bad;
	logic [15:0] supply_mv, v;
	logic [15:0] cor [6] = '{16'h4f4b, 16'h4f4c, 16'h4faf, 16'h4fb0, 16'h6979, 16'h6720};
	logic [2:0] bad [3] = '{3'h0, 3'h6, 3'h5};
	logic [7:0] e;
	logic lo, hi;
	int error_cnt, n_checks, i;
	wire conn_lost_in, chan_demand_flag, chan_error_flag, chan_operational_flag, chan_unkeyed_node;
	wire run_state_flag, link_lost_flag, diag_pending_flag, time_sync_ok, time_sync_lost;
	wire supply_low_warn, supply_high_warn, internal_error_flag, ring_mode_flag, too_many_nodes;
	wire [5:0] node_tally;
	wire [7:0] diag_event_counter;
	wire [3:0] flags = {chan_demand_flag, chan_error_flag, chan_operational_flag, chan_unkeyed_node};
	scsm_top uut (.mclk, .rst_b, .link_up, .term_present, .term_bad, .node_pulse, .node_keyed,
		.node_demand, .chan_enable, .run_mode_in, .recov_fault, .nonrecov_fault, .internal_fault,
		.conn_lost_in, .sync_locked, .ring_mode_in, .supply_mv, .chan_demand_flag, .chan_error_flag,
		.chan_operational_flag, .chan_unkeyed_node, .node_tally, .too_many_nodes, .run_state_flag,
		.link_lost_flag, .diag_pending_flag, .time_sync_ok, .time_sync_lost, .supply_low_warn,
		.supply_high_warn, .internal_error_flag, .ring_mode_flag, .diag_event_counter);
	scsm_ctrl_model ctrl (.mclk, .connected, .conn_lost_in);
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] x);
		n_checks++;
		if (s !== x)
		begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task summarize;
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task scan(input int n);
		@(posedge mclk);
		link_up <= 1'b1;
		term_present <= 1'b1;
		repeat (n)
		begin
			@(posedge mclk);
			term_present <= 1'b0;
			node_pulse <= 1'b1;
			node_keyed <= 1'b1;
			node_demand <= 1'b0;
		end
		@(posedge mclk);
		node_pulse <= 1'b0;
		term_present <= 1'b1;
		tick(4);
	endtask
	task pulse(input logic k, input logic d);
		@(posedge mclk);
		node_pulse <= 1'b1;
		node_keyed <= k;
		node_demand <= d;
		@(posedge mclk);
		node_pulse <= 1'b0;
		tick(3);
	endtask
	function logic hyst(input logic cur, input logic set, input logic clr);
		hyst = set ? 1'b1 : (clr ? 1'b0 : cur);
	endfunction
	function logic [7:0] inc(input logic [7:0] x);
		inc = (x == 8'hff) ? 8'h01 : x + 8'h01;
	endfunction
	initial
	begin
		#200000;
		error_cnt++;
		summarize;
	end
	initial
	begin
		{rst_b, link_up, term_present, node_pulse, node_keyed, node_demand, term_bad} = 7'h00;
		{chan_enable, run_mode_in, recov_fault, nonrecov_fault, internal_fault} = 5'h18;
		{sync_locked, ring_mode_in, connected} = 3'h1;
		supply_mv = 16'h5dc0;
		{error_cnt, n_checks, lo, hi} = 0;
		void'($urandom(20));
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		scan(8);
		chk(flags, 4'h2);
		chk(node_tally, 6'h08);
		for (i = 0; i < 40; i++)
		begin
			v = (i < 6) ? cor[i] : 16'h4d58 + 16'($urandom % 32'h1f40);
			@(posedge mclk);
			supply_mv <= v;
			lo = hyst(lo, v < 16'h4f4c, v >= 16'h4fb0);
			hi = hyst(hi, v > 16'h6978, v <= 16'h6720);
			tick(2);
			chk(supply_low_warn, lo);
			chk(supply_high_warn, hi);
		end
		@(posedge mclk);
		supply_mv <= 16'h5dc0;
		tick(4);
		e = inc(diag_event_counter);
		@(posedge mclk);
		internal_fault <= 1'b1;
		tick(4);
		chk(internal_error_flag, 1'b1);
		chk(diag_pending_flag, 1'b1);
		for (i = 0; i < 259; i++)
		begin
			@(posedge mclk);
			internal_fault <= ~internal_fault;
			e = inc(e);
			@(posedge mclk);
		end
		tick(4);
		chk(diag_event_counter, e);
		chk(diag_pending_flag, 1'b0);
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			{run_mode_in, recov_fault, nonrecov_fault} <= bad[i];
			tick(4);
			chk({run_state_flag, chan_operational_flag}, 2'h0);
			@(posedge mclk);
			{run_mode_in, recov_fault, nonrecov_fault} <= 3'h4;
			tick(4);
			chk({run_state_flag, chan_operational_flag}, 2'h3);
		end
		@(posedge mclk);
		{sync_locked, ring_mode_in, connected} <= 3'h6;
		tick(4);
		chk({time_sync_ok, time_sync_lost}, 2'h2);
		chk({ring_mode_flag, link_lost_flag}, 2'h3);
		@(posedge mclk);
		{sync_locked, ring_mode_in, connected} <= 3'h1;
		tick(4);
		chk({time_sync_ok, time_sync_lost}, 2'h1);
		chk({ring_mode_flag, link_lost_flag}, 2'h0);
		pulse(1'b1, 1'b1);
		chk({chan_demand_flag, chan_operational_flag}, 2'h2);
		pulse(1'b1, 1'b0);
		chk(chan_demand_flag, 1'b0);
		chk(node_tally, 6'h08);
		@(posedge mclk);
		chan_enable <= 1'b0;
		tick(4);
		chk(chan_error_flag, 1'b1);
		@(posedge mclk);
		chan_enable <= 1'b1;
		term_bad <= 1'b1;
		tick(4);
		chk(flags, 4'hc);
		@(posedge mclk);
		term_bad <= 1'b0;
		link_up <= 1'b0; // link broken before extending the chain
		term_present <= 1'b0;
		tick(4);
		chk(flags, 4'hd);
		pulse(1'b1, 1'b0);
		chk(node_tally, 6'h08);
		scan(9);
		chk(flags, 4'h2);
		chk(node_tally, 6'h09);
		pulse(1'b0, 1'b0);
		chk(flags, 4'hd);
		@(posedge mclk);
		link_up <= 1'b0;
		tick(2);
		scan(33);
		chk({too_many_nodes, flags}, 5'h1c);
		chk(node_tally, 6'h21);
		@(posedge mclk);
		rst_b <= 1'b0;
		tick(2);
		chk({diag_event_counter, flags}, 12'h00d);
		@(posedge mclk);
		rst_b <= 1'b1;
		tick(4);
		summarize;
	end
endmodule
